// [src/gpkw_ports.sv]
// Three byte-wide general ports with key-change wakeup and pin sharing.
// Assumes the serial, LED and timer engines live outside; pads resolve
// the pin level from the enables supplied here.
module gpkw_ports (
   input  wire logic                  clk_sys,
   input  wire logic                  rst_n,
   // Software side, one strobe per port in index order A, B, D
   input  wire logic [2:0]            data_we,
   input  wire logic [2:0]            dir_we,
   input  wire logic [2:0]            wake_en_we,
   input  wire logic [7:0]            wr_data,
   output      logic [2:0][7:0]       port_data_register,
   output      logic [2:0][7:0]       port_buffer_rd,
   output      logic [2:0][7:0]       port_dir_rd,
   output      logic [2:0][7:0]       port_wake_en_rd,
   // Sleep control
   input  wire logic                  sleep_cmd,
   output      logic                  sleep_active,
   output      logic                  clk_run,
   output      logic                  wakeup,
   output      logic                  wake_resume,
   // Alternate functions
   input  wire logic                  serial_en,
   input  wire logic                  serial_chip_select_pin,
   input  wire logic                  serial_clock_pin,
   input  wire logic                  serial_transmit_pin,
   output      logic                  serial_receive_pin,
   input  wire logic                  led_en,
   input  wire logic                  led_on_port_a,
   input  wire logic [3:0]            led_pulse_outputs,
   output      logic                  timer_first_ext_clk,
   output      logic                  timer_second_ext_clk,
   output      logic                  timer_third_ext_clk,
   // Pins
   input  wire logic [7:0]            port_a_pins_in,
   output      logic [7:0]            port_a_pins_out,
   output      logic [7:0]            port_a_pins_oe,
   input  wire logic [7:0]            port_b_pins_in,
   output      logic [7:0]            port_b_pins_out,
   output      logic [7:0]            port_b_pins_oe,
   input  wire logic [7:0]            port_d_pins_in,
   output      logic [7:0]            port_d_pins_out,
   output      logic [7:0]            port_d_pins_oe
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [2:0][7:0]    data;
      logic [2:0][7:0]    dir;
      logic [2:0][7:0]    wake_en;
      gpkw_pkg::gpkw_pwr_e pwr;
      logic               resume;
   } gpkw_state_s;

   gpkw_state_s     st_q;
   gpkw_state_s     st_d;
   logic [2:0][7:0] pins_raw;
   logic [2:0][7:0] pins_sync;
   logic [2:0][7:0] wake_mask;
   logic [2:0][7:0] drv_out;
   logic [2:0][7:0] drv_oe;
   logic            wake_any;

   assign pins_raw[gpkw_pkg::PORT_A] = port_a_pins_in;
   assign pins_raw[gpkw_pkg::PORT_B] = port_b_pins_in;
   assign pins_raw[gpkw_pkg::PORT_D] = port_d_pins_in;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // LED and serial alternate functions claim the low nibble of a port; timer clocks read port A bits 4-6
   function automatic logic [7:0] take_low_nibble(
      input logic [7:0] byte_now,
      input logic [3:0] nibble
   );
      take_low_nibble = {byte_now[7:4], nibble};
   endfunction : take_low_nibble

   // Strobe takes the shared write byte, otherwise the byte holds
   function automatic logic [7:0] strobe_byte(
      input logic [7:0] byte_now,
      input logic       we,
      input logic [7:0] byte_new
   );
      strobe_byte = we ? byte_new : byte_now;
   endfunction : strobe_byte

   // ----------------------------------------
   // Pin synchroniser
   // ----------------------------------------
   // Software and timers only ever see synchronised pin levels
   gpkw_sync #(
      .WIDTH (gpkw_pkg::PORT_NUM * gpkw_pkg::PORT_WIDTH)
   ) u_sync (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .async_in (pins_raw),
      .sync_out (pins_sync)
   );

   // ----------------------------------------
   // Key-change wakeup
   // ----------------------------------------
   // Pure gates on raw pins: must fire with the clock stopped.
   always_comb begin
      wake_mask = st_q.wake_en;
      if (serial_en) begin
         wake_mask[gpkw_pkg::PORT_D][3:0] = 4'h0;
      end
   end

   assign wake_any = |((pins_raw ^ st_q.data) & wake_mask);

   // ----------------------------------------
   // Register update
   // ----------------------------------------
   always_comb begin
      st_d        = st_q;
      st_d.resume = 1'b0;
      for (int p = 0; p < gpkw_pkg::PORT_NUM; p++) begin
         // Several strobes in one cycle all take the same write byte
         st_d.data[p]    = strobe_byte(st_q.data[p], data_we[p], wr_data);
         st_d.dir[p]     = strobe_byte(st_q.dir[p], dir_we[p], wr_data);
         st_d.wake_en[p] = strobe_byte(st_q.wake_en[p], wake_en_we[p], wr_data);
      end
      // Refused while a wake is pending: the clock would stop and restart at once
      // Leaving sleep raises a one-cycle resume pulse for the program counter
      case (st_q.pwr)
         gpkw_pkg::GPKW_RUN: begin
            if (sleep_cmd && !wake_any) begin
               st_d.pwr = gpkw_pkg::GPKW_SLEEP;
            end
         end
         gpkw_pkg::GPKW_SLEEP: begin
            if (wake_any) begin
               st_d.pwr    = gpkw_pkg::GPKW_RUN;
               st_d.resume = 1'b1;
            end
         end
         default: begin
            // Unknown state code falls back to running
            st_d.pwr = gpkw_pkg::GPKW_RUN;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_q.data    <= {gpkw_pkg::PORT_NUM{gpkw_pkg::DATA_RST}};
         st_q.dir     <= {gpkw_pkg::PORT_NUM{gpkw_pkg::DIR_RST}};
         st_q.wake_en <= {gpkw_pkg::PORT_NUM{gpkw_pkg::WAKE_RST}};
         st_q.pwr     <= gpkw_pkg::GPKW_RUN;
         st_q.resume  <= 1'b0;
      end else begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------
   // Pin drive and sharing
   // ----------------------------------------
   always_comb begin
      for (int p = 0; p < gpkw_pkg::PORT_NUM; p++) begin
         drv_oe[p]  = st_q.dir[p];
         drv_out[p] = st_q.data[p] & st_q.dir[p];
      end
      // LED outputs take the low nibble of B, or of A when selected
      if (led_en) begin
         if (led_on_port_a) begin
            drv_oe[gpkw_pkg::PORT_A]  = take_low_nibble(drv_oe[gpkw_pkg::PORT_A], 4'hF);
            drv_out[gpkw_pkg::PORT_A] = take_low_nibble(drv_out[gpkw_pkg::PORT_A], led_pulse_outputs);
         end else begin
            drv_oe[gpkw_pkg::PORT_B]  = take_low_nibble(drv_oe[gpkw_pkg::PORT_B], 4'hF);
            drv_out[gpkw_pkg::PORT_B] = take_low_nibble(drv_out[gpkw_pkg::PORT_B], led_pulse_outputs);
         end
      end
      // Serial interface owns D low nibble, general settings ignored
      // Placed last so it wins over every other setting on D
      if (serial_en) begin
         drv_oe[gpkw_pkg::PORT_D][gpkw_pkg::SER_CS_BIT]   = 1'b1;
         drv_out[gpkw_pkg::PORT_D][gpkw_pkg::SER_CS_BIT]  = serial_chip_select_pin;
         drv_oe[gpkw_pkg::PORT_D][gpkw_pkg::SER_CLK_BIT]  = 1'b1;
         drv_out[gpkw_pkg::PORT_D][gpkw_pkg::SER_CLK_BIT] = serial_clock_pin;
         drv_oe[gpkw_pkg::PORT_D][gpkw_pkg::SER_RX_BIT]   = 1'b0;
         drv_out[gpkw_pkg::PORT_D][gpkw_pkg::SER_RX_BIT]  = 1'b0;
         drv_oe[gpkw_pkg::PORT_D][gpkw_pkg::SER_TX_BIT]   = 1'b1;
         drv_out[gpkw_pkg::PORT_D][gpkw_pkg::SER_TX_BIT]  = serial_transmit_pin;
      end
   end

   assign port_a_pins_out = drv_out[gpkw_pkg::PORT_A];
   assign port_a_pins_oe  = drv_oe[gpkw_pkg::PORT_A];
   assign port_b_pins_out = drv_out[gpkw_pkg::PORT_B];
   assign port_b_pins_oe  = drv_oe[gpkw_pkg::PORT_B];
   assign port_d_pins_out = drv_out[gpkw_pkg::PORT_D];
   assign port_d_pins_oe  = drv_oe[gpkw_pkg::PORT_D];

   // ----------------------------------------
   // Reads and alternate inputs
   // ----------------------------------------
   assign port_data_register = st_q.data;
   assign port_buffer_rd     = pins_sync;
   assign port_dir_rd        = st_q.dir;
   assign port_wake_en_rd    = st_q.wake_en;

   // Held low while disabled so the engine sees no stray edges
   assign serial_receive_pin = serial_en & pins_sync[gpkw_pkg::PORT_D][gpkw_pkg::SER_RX_BIT];

   assign timer_first_ext_clk  = pins_sync[gpkw_pkg::PORT_A][gpkw_pkg::TMR_A_BIT];
   assign timer_second_ext_clk = pins_sync[gpkw_pkg::PORT_A][gpkw_pkg::TMR_B_BIT];
   assign timer_third_ext_clk  = pins_sync[gpkw_pkg::PORT_A][gpkw_pkg::TMR_C_BIT];

   // ----------------------------------------
   // Sleep and clock restart
   // ----------------------------------------
   assign sleep_active = (st_q.pwr == gpkw_pkg::GPKW_SLEEP);
   assign wakeup       = wake_any;
   // Clock request bypasses flops so a stopped clock can restart
   assign clk_run      = !sleep_active || wake_any;
   assign wake_resume  = st_q.resume;

endmodule : gpkw_ports

// [src/gpkw_pkg.sv]
// Constants shared by the port block and its synchroniser.
// Assumes a single 40 MHz system clock and an active-low asynchronous reset.
// Functional notes
// - Twenty-four pins as three byte-wide ports.
// - Every pin does input, output and wakeup.
// - Write fills latch only; buffer reads synced pins.
// - Wakeup when pin differs from latched reference.
// - Serial select, clock, data on port D low nibble.
// - Serial enable overrides general settings on D low nibble.
// - LED outputs on B or A low nibble.
// - Port A bits 4-6 feed timer clocks.
// - Wakeup restarts clock, resumes after sleep.
package gpkw_pkg;

   // ----------------------------------------
   // Geometry
   // ----------------------------------------
   localparam int PORT_NUM   = 3;
   localparam int PORT_WIDTH = 8;
   localparam int PORT_A     = 0;
   localparam int PORT_B     = 1;
   localparam int PORT_D     = 2;

   // ----------------------------------------
   // Shared pin positions
   // ----------------------------------------
   localparam int SER_CS_BIT  = 0;
   localparam int SER_CLK_BIT = 1;
   localparam int SER_RX_BIT  = 2;
   localparam int SER_TX_BIT  = 3;
   localparam int LED_NUM     = 4;
   localparam int TMR_A_BIT   = 4;
   localparam int TMR_B_BIT   = 5;
   localparam int TMR_C_BIT   = 6;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [7:0] DIR_RST  = 8'h00;
   localparam logic [7:0] WAKE_RST = 8'h00;
   localparam int         SYNC_STAGES = 2;

   typedef enum logic [1:0] {
      GPKW_RUN   = 2'b01,
      GPKW_SLEEP = 2'b10
   } gpkw_pwr_e;

endpackage : gpkw_pkg

// [src/gpkw_sync.sv]
// Two-stage level synchroniser for pin inputs.
// Assumes inputs may change at any time relative to clk_sys.
module gpkw_sync #(
   parameter int WIDTH = 24
) (
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] async_in,
   output      logic [WIDTH-1:0] sync_out
);

   typedef struct packed {
      logic [WIDTH-1:0] first;
      logic [WIDTH-1:0] second;
   } gpkw_sync_s;

   gpkw_sync_s st_q;
   gpkw_sync_s st_d;

   always_comb begin
      st_d        = st_q;
      st_d.first  = async_in;
      st_d.second = st_q.first;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign sync_out = st_q.second;

endmodule : gpkw_sync

// [sim/gpkw_ports_monitor.sv]
// Concurrent checks on the pins, sleep and sharing ports of gpkw_ports.
// Assumes released pins read low, so the synchroniser history is zero in reset.
module gpkw_ports_monitor (
   input wire logic            clk_sys,
   input wire logic            rst_n,
   input wire logic            sleep_cmd,
   input wire logic            sleep_active,
   input wire logic            clk_run,
   input wire logic            wakeup,
   input wire logic            wake_resume,
   input wire logic            serial_en,
   input wire logic            serial_chip_select_pin,
   input wire logic            serial_clock_pin,
   input wire logic            serial_transmit_pin,
   input wire logic            serial_receive_pin,
   input wire logic            led_en,
   input wire logic            led_on_port_a,
   input wire logic            timer_first_ext_clk,
   input wire logic            timer_second_ext_clk,
   input wire logic            timer_third_ext_clk,
   input wire logic [2:0]      data_we,
   input wire logic [3:0]      led_pulse_outputs,
   input wire logic [7:0]      wr_data,
   input wire logic [7:0]      port_a_pins_in,
   input wire logic [7:0]      port_a_pins_out,
   input wire logic [7:0]      port_a_pins_oe,
   input wire logic [7:0]      port_b_pins_in,
   input wire logic [7:0]      port_b_pins_out,
   input wire logic [7:0]      port_b_pins_oe,
   input wire logic [7:0]      port_d_pins_in,
   input wire logic [7:0]      port_d_pins_out,
   input wire logic [7:0]      port_d_pins_oe,
   input wire logic [2:0][7:0] port_data_register,
   input wire logic [2:0][7:0] port_buffer_rd,
   input wire logic [2:0][7:0] port_dir_rd,
   input wire logic [2:0][7:0] port_wake_en_rd
);
   timeunit 1ns;
   timeprecision 1ps;
   logic wake_exp;
   // Serial ownership hides the low nibble of D from the compare
   assign wake_exp = |((port_a_pins_in ^ port_data_register[0]) & port_wake_en_rd[0])
                   | |((port_b_pins_in ^ port_data_register[1]) & port_wake_en_rd[1])
                   | |((port_d_pins_in ^ port_data_register[2]) & port_wake_en_rd[2] & {4'hF, {4{!serial_en}}});
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   data_wr_a: assert property (data_we[0] |=> port_data_register[0] == $past(wr_data)) else $error("latch write lost");
   wake_cmp_a: assert property (wakeup == wake_exp) else $error("wake compare wrong");
   sleep_enter_a: assert property (sleep_cmd && !wakeup && !sleep_active |=> sleep_active) else $error("no sleep");
   sleep_refuse_a: assert property (!sleep_active && wakeup |=> !sleep_active) else $error("slept on wake");
   wake_exit_a: assert property (sleep_active && wakeup |=> !sleep_active && wake_resume ##1 !wake_resume)
      else $error("bad wake exit");
   clk_stop_a: assert property (clk_run == !(sleep_active && !wakeup)) else $error("clock run wrong");
   sync_rd_a: assert property (port_buffer_rd == $past({port_d_pins_in, port_b_pins_in, port_a_pins_in}, 2))
      else $error("pin read not synced");
   timer_clk_a: assert property ({timer_third_ext_clk, timer_second_ext_clk, timer_first_ext_clk}
      == $past(port_a_pins_in[6:4], 2)) else $error("timer clock wrong");
   serial_own_a: assert property (serial_en |-> port_d_pins_oe[3:0] == 4'hB
      && port_d_pins_out[3] == serial_transmit_pin
      && port_d_pins_out[1:0] == {serial_clock_pin, serial_chip_select_pin}) else $error("serial pins wrong");
   serial_rx_a: assert property (serial_receive_pin == (serial_en && $past(port_d_pins_in[2], 2)))
      else $error("serial receive wrong");
   led_route_a: assert property (led_en |-> (led_on_port_a ? {port_a_pins_oe[3:0], port_a_pins_out[3:0]}
      : {port_b_pins_oe[3:0], port_b_pins_out[3:0]}) == {4'hF, led_pulse_outputs}) else $error("led route wrong");
   gpio_out_a: assert property (!led_en |-> port_b_pins_oe == port_dir_rd[1]
      && port_b_pins_out == (port_data_register[1] & port_dir_rd[1])) else $error("port out wrong");
   cover property (sleep_active && wakeup);
   cover property (serial_en && port_d_pins_in[2]);
   cover property (led_en && led_on_port_a);
endmodule : gpkw_ports_monitor

bind gpkw_ports gpkw_ports_monitor u_gpkw_ports_monitor (.*);

// [sim/gpkw_pins_model.sv]
// Keys and pull-low resistors on the 24 pins, ordered {D, B, A}.
// Assumes the device wins where both drive; keys are plain levels.
module gpkw_pins_model (
   input  wire logic [23:0] dev_out,
   input  wire logic [23:0] dev_oe,
   input  wire logic [23:0] key_val,
   input  wire logic [23:0] key_en,
   output      logic [23:0] pins
);
   timeunit 1ns;
   timeprecision 1ps;
   // Released pins fall to the pull-low level
   always_comb begin
      for (int i = 0; i < 24; i++) pins[i] = dev_oe[i] ? dev_out[i] : (key_en[i] & key_val[i]);
   end
endmodule : gpkw_pins_model

// [sim/gpkw_ports_bench.sv]
// Self-checking bench for gpkw_ports with the pin model on the far side.
// Assumes strobes are one cycle wide and reads settle two edges after a pin moves.
module gpkw_ports_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys, rst_n, sleep_cmd, serial_en, cs, sck, tx, led_en, led_a;
   logic sleep_active, clk_run, wakeup, wake_resume, rx, t1, t2, t3;
   logic [3:0] led;
   logic [2:0] data_we, dir_we, wake_en_we;
   logic [7:0] wr_data;
   logic [23:0] key, key_en, pins;
   wire logic [23:0] dout, doe;
   logic [2:0][7:0] dreg, buf_rd, dir_rd, wen_rd;
   int n_fail, samples_checked;
   gpkw_ports u_gpkw_ports (.clk_sys(clk_sys), .rst_n(rst_n), .data_we(data_we), .dir_we(dir_we),
      .wake_en_we(wake_en_we), .wr_data(wr_data), .port_data_register(dreg), .port_buffer_rd(buf_rd),
      .port_dir_rd(dir_rd), .port_wake_en_rd(wen_rd), .sleep_cmd(sleep_cmd), .sleep_active(sleep_active),
      .clk_run(clk_run), .wakeup(wakeup), .wake_resume(wake_resume), .serial_en(serial_en),
      .serial_chip_select_pin(cs), .serial_clock_pin(sck), .serial_transmit_pin(tx), .serial_receive_pin(rx),
      .led_en(led_en), .led_on_port_a(led_a), .led_pulse_outputs(led), .timer_first_ext_clk(t1),
      .timer_second_ext_clk(t2), .timer_third_ext_clk(t3), .port_a_pins_in(pins[7:0]),
      .port_a_pins_out(dout[7:0]), .port_a_pins_oe(doe[7:0]), .port_b_pins_in(pins[15:8]),
      .port_b_pins_out(dout[15:8]), .port_b_pins_oe(doe[15:8]), .port_d_pins_in(pins[23:16]),
      .port_d_pins_out(dout[23:16]), .port_d_pins_oe(doe[23:16]));
   gpkw_pins_model u_gpkw_pins_model (.dev_out(dout), .dev_oe(doe), .key_val(key), .key_en(key_en), .pins(pins));
   task automatic chk(input logic [23:0] s, input logic [23:0] e);
      samples_checked++;
      if (s !== e) begin
         n_fail++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   // Kind 0 data, 1 direction, 2 wake enable
   task automatic wr(input int k, input int p, input logic [7:0] d);
      @(posedge clk_sys);
      {wake_en_we, dir_we, data_we} <= 9'h001 << (k * 3 + p);
      wr_data <= d;
      @(posedge clk_sys);
      {wake_en_we, dir_we, data_we} <= 9'h000;
   endtask : wr
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : cyc
   task automatic finish_test;
      $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : finish_test
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (2000) @(posedge clk_sys);
      n_fail++;
      finish_test;
   end
   initial begin
      rst_n = 1'b0;
      {data_we, dir_we, wake_en_we, wr_data, sleep_cmd, serial_en, cs, sck, tx, led_en, led_a, led} = '0;
      key = '0;
      key_en = '0;
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      cyc(1);
      chk(dreg, 24'h000000);
      chk(doe, 24'h000000);
      for (int p = 0; p < 3; p++) begin
         wr(1, p, 8'hFF);
         wr(0, p, 8'hA5 ^ 8'(p));
         cyc(2);
         chk(buf_rd[p], 8'hA5 ^ 8'(p));
         chk(dir_rd[p], 8'hFF);
         wr(1, p, 8'h00);
         key_en[p*8+:8] <= 8'hFF;
         key[p*8+:8] <= 8'h3C;
         cyc(3);
         chk(buf_rd[p], 8'h3C);
         chk(dreg[p], 8'hA5 ^ 8'(p));
         @(posedge clk_sys) key_en <= '0;
      end
      wr(0, 0, 8'h00);
      wr(2, 0, 8'h80);
      cyc(1);
      chk({wen_rd[0], wakeup}, 9'h100);
      @(posedge clk_sys) sleep_cmd <= 1'b1;
      @(posedge clk_sys) sleep_cmd <= 1'b0;
      #1 chk({sleep_active, clk_run}, 2'b10);
      @(posedge clk_sys) {key_en[7], key[7]} <= 2'b11;
      #1 chk({wakeup, clk_run}, 2'b11);
      cyc(1);
      chk({sleep_active, wake_resume}, 2'b01);
      @(posedge clk_sys) sleep_cmd <= 1'b1;
      @(posedge clk_sys) sleep_cmd <= 1'b0;
      #1 chk(sleep_active, 1'b0);
      @(posedge clk_sys) key_en <= '0;
      wr(2, 0, 8'h00);
      wr(1, 2, 8'hFF);
      wr(0, 2, 8'h00);
      wr(2, 2, 8'h0F);
      {serial_en, cs, sck, tx, key_en[18], key[18]} <= 6'b110111;
      cyc(3);
      chk(doe[23:16], 8'hFB);
      chk({dout[19], dout[17:16], rx, wakeup}, 5'b10110);
      @(posedge clk_sys) {serial_en, key_en[18]} <= 2'b00;
      cyc(1);
      chk(doe[23:16], 8'hFF);
      wr(2, 2, 8'h00);
      {led_en, led_a, led} <= 6'b101001;
      cyc(1);
      chk({doe[15:8], dout[11:8]}, 12'h0F9);
      @(posedge clk_sys) led_a <= 1'b1;
      cyc(1);
      chk({doe[7:0], dout[3:0], doe[15:8]}, 20'h0F900);
      @(posedge clk_sys) led_en <= 1'b0;
      {key_en[6:4], key[6:4]} <= 6'b111101;
      cyc(3);
      chk({t3, t2, t1}, 3'b101);
      finish_test;
   end
endmodule : gpkw_ports_bench
